// ### timer_defines.svh
// Register indices, field positions and reset values of the event/count block
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ---------------------------------------------
// Register indices (byte address is 4 x index)
// ---------------------------------------------
`define IDX_EVENT_CONTROL 8'h09
`define IDX_INTERRUPT_ENABLE 8'h0A
`define IDX_INTERRUPT_FLAGS 8'h0B
`define IDX_DEBUG_CONTROL 8'h0E
`define IDX_BYTE_LATCH 8'h0F
`define IDX_COUNT_LOW 8'h20
`define IDX_COUNT_HIGH 8'h21

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define EVENT_COUNT_ENABLE_BIT 0
`define EVENT_ACTION_LSB 1
`define EVENT_ACTION_MSB 3
`define WRAP_BIT 0
`define COMPARE_ZERO_BIT 4
`define COMPARE_TWO_BIT 6
`define RUN_WHILE_HALTED_BIT 0

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define RESET_BYTE 8'h00
`define RESET_COUNT 16'h0000

`endif

// ### timer_pkg.sv
// Types shared by the event/count block
package timer_pkg;

   // ---------------------------------------------
   // Event action codes
   // ---------------------------------------------
   typedef enum logic [2:0] {
      action_rising_edge_count = 3'h0,
      action_both_edge_count = 3'h1,
      action_gated_high_count = 3'h2,
      action_direction_control = 3'h3
   } event_action_type;

   // ---------------------------------------------
   // Waveform mode codes that steer the wrap flag
   // ---------------------------------------------
   typedef enum logic [2:0] {
      wave_normal = 3'h0,
      wave_frequency = 3'h1,
      wave_single_slope = 3'h3,
      wave_dual_top = 3'h5,
      wave_dual_both = 3'h6,
      wave_dual_bottom = 3'h7
   } waveform_mode_select_type;

   // ---------------------------------------------
   // Bus read sequencing, one bit flips per step except bus_read_out to bus_idle
   // ---------------------------------------------
   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_read_wait = 2'b01,
      bus_read_out = 2'b11
   } bus_state_type;

endpackage

// ### timer_event_irq_count_regs.sv
// Event input, interrupt flags, debug control and count register of a 16-bit timer
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "timer_defines.svh"

// Summary of operation
// [R1] Event action select is bits 3:1 of event control register.
// [R2] Code 0: count once per rising edge of the event input.
// [R3] Code 1: count once per rising or falling event edge.
// [R4] Code 2: count prescaled ticks only while the event input is high.
// [R5] Code 3: count ticks up while event low, down while event high.
// [R6] Code 3: direction is latched when a count step happens.
// [R7] Bit 0 enables event counting; clear means plain tick counting.
// [R8] Bits 4..6 of interrupt enable gate compare channel 0..2 requests.
// [R9] Bit 0 of interrupt enable gates the wrap request.
// [R10] Compare flag sets whenever count equals that channel's compare value.
// [R11] Compare flag clears only by writing one to its bit.
// [R12] Wrap flag sets on top or bottom as the waveform mode selects.
// [R13] Wrap flag clears only by writing one to its bit.
// [R14] Run-while-halted zero: stop counting and ignore events in debug halt.
// [R15] Run-while-halted one: keep running during debug halt.
// [R16] One shared byte latch at index 0x0F, readable and writable.
// [R17] Count low byte at index 0x20, high byte at 0x21.
// [R18] Direction reads one when counting down, zero when counting up.
// [R19] Low write parks in latch, high write commits; low read snapshots high.
// [R20] Reserved actions do not count; writing zero leaves flags unchanged.

module timer_event_irq_count_regs (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic timer_enable,
   input wire logic prescale_tick,
   input wire logic event_in,
   input wire logic debug_halt,
   input wire timer_pkg::waveform_mode_select_type waveform_mode_select,
   input wire logic [15:0] period_value,
   input wire logic [15:0] compare_value_register_0,
   input wire logic [15:0] compare_value_register_1,
   input wire logic [15:0] compare_value_register_2,
   output logic [15:0] count_value,
   output logic count_direction,
   output logic [2:0] compare_match,
   output logic wrap_irq_request,
   output logic [2:0] compare_irq_request
);
   import timer_pkg::*;

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   logic [7:0] event_control;
   logic [7:0] interrupt_enable;
   logic [7:0] interrupt_flags;
   logic [7:0] debug_control;
   logic [7:0] wide_access_byte_latch;
   logic event_prev;
   bus_state_type bus_state;
   logic wr_pending;
   logic [7:0] wr_index;
   logic [7:0] rd_index;

   // ---------------------------------------------
   // Address decode
   // ---------------------------------------------
   function automatic logic [7:0] word_index(input logic [31:0] addr);
      word_index = addr[9:2];
   endfunction

   logic take;
   logic take_rd;
   logic take_wr;
   logic [7:0] addr_index;
   logic wr_now;
   logic rd_now;
   logic [7:0] wdata;

   assign take = hsel && hready && htrans[1];
   assign take_rd = take && !hwrite;
   assign take_wr = take && hwrite;
   assign addr_index = word_index(haddr);
   assign wr_now = wr_pending;
   assign rd_now = (bus_state == bus_read_wait);
   assign wdata = hwdata[7:0];

   // ---------------------------------------------
   // Bus sequencing
   // ---------------------------------------------
   // Reads take one wait state so that hrdata comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state <= bus_idle;
      end else begin
         unique case (bus_state)
            bus_idle: begin
               if (take_rd) begin
                  bus_state <= bus_read_wait;
               end
            end
            bus_read_wait: begin
               bus_state <= bus_read_out;
            end
            bus_read_out: begin
               if (take_rd) begin
                  bus_state <= bus_read_wait;
               end else begin
                  bus_state <= bus_idle;
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_index <= 8'h00;
         rd_index <= 8'h00;
      end else begin
         wr_pending <= take_wr;
         if (take_wr) begin
            wr_index <= addr_index;
         end
         if (take_rd) begin
            rd_index <= addr_index;
         end
      end
   end

   assign hreadyout = (bus_state != bus_read_wait);
   assign hresp = 1'b0;

   // ---------------------------------------------
   // Read data
   // ---------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_now) begin
         hrdata <= 32'h0000_0000;
         unique case (rd_index)
            `IDX_EVENT_CONTROL: hrdata[7:0] <= event_control;
            `IDX_INTERRUPT_ENABLE: hrdata[7:0] <= interrupt_enable;
            `IDX_INTERRUPT_FLAGS: hrdata[7:0] <= interrupt_flags;
            `IDX_DEBUG_CONTROL: hrdata[7:0] <= debug_control;
            `IDX_BYTE_LATCH: hrdata[7:0] <= wide_access_byte_latch; // see [R16]
            `IDX_COUNT_LOW: hrdata[7:0] <= count_value[7:0]; // see [R17]
            `IDX_COUNT_HIGH: hrdata[7:0] <= wide_access_byte_latch; // see [R19]
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------
   // Control registers
   // ---------------------------------------------
   // Reserved bits are masked off so they read as zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_control <= `RESET_BYTE;
         interrupt_enable <= `RESET_BYTE;
         debug_control <= `RESET_BYTE;
      end else if (wr_now) begin
         if (wr_index == `IDX_EVENT_CONTROL) begin
            event_control <= wdata & 8'h0F; // see [R1] [R7]
         end
         if (wr_index == `IDX_INTERRUPT_ENABLE) begin
            interrupt_enable <= wdata & 8'h71; // see [R8] [R9]
         end
         if (wr_index == `IDX_DEBUG_CONTROL) begin
            debug_control <= wdata & 8'h01;
         end
      end
   end

   // ---------------------------------------------
   // Shared byte latch
   // ---------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wide_access_byte_latch <= `RESET_BYTE;
      end else if (rd_now && rd_index == `IDX_COUNT_LOW) begin
         wide_access_byte_latch <= count_value[15:8]; // see [R19]
      end else if (wr_now && (wr_index == `IDX_BYTE_LATCH ||
                              wr_index == `IDX_COUNT_LOW)) begin
         wide_access_byte_latch <= wdata; // see [R16] [R19]
      end
   end

   // ---------------------------------------------
   // Count step decision
   // ---------------------------------------------
   event_action_type action;
   logic event_count_enable;
   logic run_while_halted;
   logic frozen;
   logic rise;
   logic fall;
   logic step;
   logic step_down;

   assign action = event_action_type'(
      event_control[`EVENT_ACTION_MSB:`EVENT_ACTION_LSB]);
   assign event_count_enable = event_control[`EVENT_COUNT_ENABLE_BIT];
   assign run_while_halted = debug_control[`RUN_WHILE_HALTED_BIT];
   assign frozen = debug_halt && !run_while_halted; // see [R14] [R15]
   assign rise = event_in && !event_prev;
   assign fall = !event_in && event_prev;

   always_comb begin
      step = 1'b0;
      step_down = count_direction;
      if (timer_enable && !frozen) begin
         if (!event_count_enable) begin
            step = prescale_tick; // see [R7]
         end else begin
            unique case (action)
               action_rising_edge_count: step = rise; // see [R2]
               action_both_edge_count: step = rise || fall; // see [R3]
               action_gated_high_count: step = prescale_tick && event_in; // see [R4]
               action_direction_control: begin
                  step = prescale_tick; // see [R5]
                  step_down = event_in; // see [R5]
               end
               default: step = 1'b0; // see [R20]
            endcase
         end
      end
   end

   // Edge history keeps tracking while halted so release gives no false edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_prev <= 1'b0;
      end else begin
         event_prev <= event_in;
      end
   end

   // ---------------------------------------------
   // Direction
   // ---------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_direction <= 1'b0;
      end else if (step && event_count_enable &&
                   action == action_direction_control) begin
         count_direction <= event_in; // see [R6] [R18]
      end
   end

   // ---------------------------------------------
   // Counter
   // ---------------------------------------------
   logic at_top;
   logic at_bottom;
   logic top_event;
   logic bottom_event;

   assign at_top = (count_value == period_value);
   assign at_bottom = (count_value == 16'h0000);
   assign top_event = step && !step_down && at_top;
   assign bottom_event = step && step_down && at_bottom;

   // Software write of the high byte wins over a count step
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_value <= `RESET_COUNT;
      end else if (wr_now && wr_index == `IDX_COUNT_HIGH) begin
         count_value <= {wdata, wide_access_byte_latch}; // see [R17] [R19]
      end else if (step) begin
         if (step_down) begin
            count_value <= at_bottom ? period_value : count_value - 16'h0001;
         end else begin
            count_value <= at_top ? 16'h0000 : count_value + 16'h0001;
         end
      end
   end

   // ---------------------------------------------
   // Wrap and compare flags
   // ---------------------------------------------
   logic wrap_set;
   logic [2:0] flag_clear;

   always_comb begin
      unique case (waveform_mode_select)
         wave_normal, wave_frequency: wrap_set = top_event || bottom_event;
         wave_single_slope, wave_dual_bottom: wrap_set = bottom_event;
         wave_dual_top: wrap_set = top_event;
         wave_dual_both: wrap_set = top_event || bottom_event;
         default: wrap_set = 1'b0;
      endcase
   end

   assign compare_match[0] = (count_value == compare_value_register_0); // see [R10]
   assign compare_match[1] = (count_value == compare_value_register_1); // see [R10]
   assign compare_match[2] = (count_value == compare_value_register_2); // see [R10]

   logic flag_write;
   assign flag_write = wr_now && wr_index == `IDX_INTERRUPT_FLAGS;

   // Set beats a same-cycle clear so no event is lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_flags <= `RESET_BYTE;
      end else begin
         if (wrap_set) begin
            interrupt_flags[`WRAP_BIT] <= 1'b1; // see [R12]
         end else if (flag_write && wdata[`WRAP_BIT]) begin
            interrupt_flags[`WRAP_BIT] <= 1'b0; // see [R13] [R20]
         end
         for (int i = 0; i < 3; i++) begin
            if (compare_match[i]) begin
               interrupt_flags[`COMPARE_ZERO_BIT + i] <= 1'b1; // see [R10]
            end else if (flag_write && wdata[`COMPARE_ZERO_BIT + i]) begin
               interrupt_flags[`COMPARE_ZERO_BIT + i] <= 1'b0; // see [R11] [R20]
            end
         end
      end
   end

   // ---------------------------------------------
   // Interrupt requests
   // ---------------------------------------------
   assign wrap_irq_request = interrupt_flags[`WRAP_BIT] &&
                             interrupt_enable[`WRAP_BIT]; // see [R9]
   assign compare_irq_request =
      interrupt_flags[`COMPARE_TWO_BIT:`COMPARE_ZERO_BIT] &
      interrupt_enable[`COMPARE_TWO_BIT:`COMPARE_ZERO_BIT]; // see [R8]

endmodule

// ### timer_event_props.sv
// Port assertions for the event/count block
`timescale 1ns/1ps
module timer_event_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic timer_enable,
   input wire logic [15:0] count_value,
   input wire logic count_direction,
   input wire logic [2:0] compare_match,
   input wire logic wrap_irq_request,
   input wire logic [2:0] compare_irq_request
);
   logic wr_data;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------
   // Bus phases
   // ----------
   sequence take_read;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence read_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   // Write data phase; a write may legally move count or flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         wr_data <= 1'b0;
      else
         wr_data <= hsel && hready && htrans[1] && hwrite;
   end
   a_read_one_wait: assert property (take_read |=> read_answer)
      else $error("read answer timing wrong");
   a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write stalled");
   a_bus_okay: assert property (hreadyout |-> !hresp && hrdata[31:8] == 24'h000000)
      else $error("bad response or upper read bits");
   a_count_frozen: assert property (!timer_enable && !wr_data |=> $stable(count_value))
      else $error("count moved while stopped");
   a_step_direction: assert property ($changed(count_value) && !$past(wr_data) |->
      (count_direction ? (count_value == $past(count_value) - 16'h0001
      || $past(count_value) == 16'h0000) : (count_value == $past(count_value) + 16'h0001
      || count_value == 16'h0000)))
      else $error("count step disagrees with direction");
   a_wrap_sticky: assert property ($fell(wrap_irq_request) |-> $past(wr_data))
      else $error("wrap request dropped without a write");
   a_cmp_sticky: assert property (|($past(compare_irq_request) & ~compare_irq_request)
      |-> $past(wr_data))
      else $error("compare request dropped without a write");
   a_match_sets: assert property ($rose(compare_irq_request[0]) |->
      $past(compare_match[0]) || $past(wr_data))
      else $error("compare request without a match");
endmodule
bind timer_event_irq_count_regs timer_event_props i_props (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .hresp, .hrdata, .timer_enable, .count_value,
   .count_direction, .compare_match, .wrap_irq_request, .compare_irq_request);

// ### event_source.sv
// Event channel model: random event level and prescaler pulses
`timescale 1ns/1ps
module event_source (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic active,
   output logic event_in,
   output logic prescale_tick
);
   // Level toggles at random spacing, so edges come both fast and slow
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_in <= 1'b0;
         prescale_tick <= 1'b0;
      end else if (active) begin
         event_in <= event_in ^ ($urandom_range(0, 3) == 0);
         prescale_tick <= 1'($urandom_range(0, 1));
      end else begin
         prescale_tick <= 1'b0;
      end
   end
endmodule

// ### testbench.sv
// Self-checking bench for the event/count block with a running model
`timescale 1ns/1ps
module testbench;
   import timer_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, active, go, wrap, m_dir, m_prev;
   logic timer_enable, prescale_tick, event_in, debug_halt, count_direction, wrap_irq_request;
   logic [1:0] htrans;
   logic [2:0] hsize, compare_match, compare_irq_request;
   logic [3:0] ex;
   logic [31:0] haddr, hwdata, hrdata;
   logic [15:0] period_value, count_value, m_cnt;
   logic [15:0] cv [3];
   waveform_mode_select_type waveform_mode_select;
   waveform_mode_select_type wm [6] = '{wave_normal, wave_frequency, wave_single_slope,
      wave_dual_top, wave_dual_both, wave_dual_bottom};
   logic [7:0] rd, m_ev, m_ie, m_flags, m_dbg, m_latch;
   logic [7:0] regs [8] = '{8'h09, 8'h0A, 8'h0B, 8'h0E, 8'h0F, 8'h20, 8'h21, 8'h30};
   int mismatches, checks_done, cycles, act;
   assign hready = hreadyout;
   timer_event_irq_count_regs i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .timer_enable, .prescale_tick, .event_in,
      .debug_halt, .waveform_mode_select, .period_value, .compare_value_register_0(cv[0]),
      .compare_value_register_1(cv[1]), .compare_value_register_2(cv[2]), .count_value,
      .count_direction, .compare_match, .wrap_irq_request, .compare_irq_request);
   event_source i_events (.hclk, .hresetn, .active, .event_in, .prescale_tick);
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // -----------
   // Model
   // -----------
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 10000) begin
         mismatches++;
         summarize();
      end
      act = m_ev[0] ? int'(m_ev[3:1]) : 8;
      go = 1'b0;
      if (hresetn && timer_enable && !(debug_halt && !m_dbg[0]))
         case (act)
            0: go = event_in && !m_prev;
            1: go = event_in != m_prev;
            2: go = prescale_tick && event_in;
            3, 8: go = prescale_tick;
            default: go = 1'b0;
         endcase
      for (int k = 0; k < 3; k++)
         if (hresetn && m_cnt == cv[k]) m_flags[4 + k] = 1'b1;
      if (go) begin
         if (act == 3) m_dir = event_in;
         wrap = m_dir ? m_cnt == 16'h0000 : m_cnt == period_value;
         if (m_dir) m_cnt = wrap ? period_value : m_cnt - 16'h0001;
         else m_cnt = wrap ? 16'h0000 : m_cnt + 16'h0001;
         // Top wrap and bottom wrap raise the flag only in the modes that claim them
         if (wrap && (m_dir ? waveform_mode_select inside {wave_normal, wave_frequency,
               wave_single_slope, wave_dual_both, wave_dual_bottom}
               : waveform_mode_select inside {wave_normal, wave_frequency, wave_dual_top,
               wave_dual_both})) m_flags[0] = 1'b1;
      end
      m_prev = event_in;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      logic [7:0] exp;
      htrans <= 2'b10;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= wr;
      do @(posedge hclk); while (!hready);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (!hready);
      rd = hrdata[7:0];
      case (idx)
         8'h09: exp = m_ev;
         8'h0A: exp = m_ie;
         8'h0B: exp = m_flags;
         8'h0E: exp = m_dbg;
         8'h0F, 8'h21: exp = m_latch;
         8'h20: exp = m_cnt[7:0];
         default: exp = 8'h00;
      endcase
      if (!wr) check("register", rd, exp);
      if (wr) case (idx)
         8'h09: m_ev = wd & 8'h0F;
         8'h0A: m_ie = wd & 8'h71;
         8'h0B: m_flags = m_flags & ~wd;
         8'h0E: m_dbg = wd & 8'h01;
         8'h0F, 8'h20: m_latch = wd;
         8'h21: m_cnt = {wd, m_latch};
         default: ;
      endcase
      else if (idx == 8'h20) m_latch = m_cnt[15:8];
   endtask
   task automatic ports();
      @(negedge hclk);
      check("count", count_value, m_cnt);
      check("direction", count_direction, m_dir);
      ex = {1'b0, m_cnt == cv[2], m_cnt == cv[1], m_cnt == cv[0]};
      check("match", compare_match, ex[2:0]);
      ex = {m_flags[0] & m_ie[0], m_flags[6:4] & m_ie[6:4]};
      check("requests", {wrap_irq_request, compare_irq_request}, ex);
      @(posedge hclk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // -----------
   // Tests
   // -----------
   initial begin
      void'($urandom(4143));
      {hsel, hwrite, active, timer_enable, debug_halt, hresetn} = 6'b100000;
      {htrans, hsize, haddr, hwdata} = {2'b00, 3'b010, 64'h0};
      {m_ev, m_ie, m_flags, m_dbg, m_latch, m_cnt, m_dir, m_prev} = '0;
      cv = '{16'h0000, 16'h0000, 16'h0000};
      period_value = 16'hFFFF;
      waveform_mode_select = wave_normal;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      for (int p = 0; p < 2; p++)
         for (int k = 0; k < 8; k++) begin
            if (p == 1) bus(1'b1, regs[k], 8'hFF);
            bus(1'b0, regs[k], 8'h00);
         end
      $display("register test done");
      // Runs 0-7 walk every action code, 8 plain ticks, 9-10 debug halt
      for (int r = 0; r < 11; r++) begin
         period_value <= 16'($urandom_range(40, 90));
         waveform_mode_select <= wm[$urandom_range(0, 5)];
         foreach (cv[k]) cv[k] <= 16'($urandom_range(0, 90));
         bus(1'b1, 8'h20, 8'($urandom_range(0, 39)));
         bus(1'b1, 8'h21, 8'h00);
         bus(1'b1, 8'h09, r < 8 ? {4'h0, 3'(r), 1'b1} : {4'h0, 3'(r % 2 * 3), 1'(r % 2)});
         bus(1'b1, 8'h0E, {7'h0, r == 10});
         debug_halt <= r > 8;
         {timer_enable, active} <= 2'b11;
         repeat (150) @(posedge hclk);
         {timer_enable, active} <= 2'b00;
         ports();
         bus(1'b0, 8'h20, 8'h00);
         bus(1'b0, 8'h21, 8'h00);
         bus(1'b1, 8'h0A, 8'($urandom));
         ports();
         bus(1'b1, 8'h0B, 8'h00);
         bus(1'b0, 8'h0B, 8'h00);
         bus(1'b1, 8'h0B, 8'hFF);
         bus(1'b0, 8'h0B, 8'h00);
         ports();
         debug_halt <= 1'b0;
         $display("run %0d done", r);
      end
      summarize();
   end
endmodule
